// ### hw/rtc_domain_power_wake_control.v
// RTC domain power-down, wake pin, clock-out and event flag control with APB access
//
// How it works
// - Direction bit selects wake pin input/output
// - Input active high, output open-drain active low
// - Bandgap power-down stops regulators, reset comparator, bandgap
// - Bandgap shutdown ends on pin, alarm, periodic
// - Regulator power-down stops regulators and reset comparator
// - Bandgap stays on; same three wake sources
// - Clock-out pin follows enable bit
// - Sixteen-bit flags: alarm bit 15, events 5:0
// - Events set flags; writing one clears
// - Wake pin assertion sets external event flag
// - Wake data bit: 0 drives low, 1 floats
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pwr_regs.vh"

module rtc_domain_power_wake_control #(
   parameter ADDR_WIDTH = 16,
   parameter PERIODIC_EVENTS = 5
) (
   input wire mclk,
   input wire srst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire [31:0] prdata,
   output wire pslverr,
   // Events from the RTC counters, one-cycle pulses
   input wire alarm_event,
   input wire [PERIODIC_EVENTS-1:0] periodic_event,
   // Wake pin as three signals
   input wire wake_pin_in,
   output wire wake_pin_out,
   output wire wake_pin_oe,
   // RTC clock and its gated copy for the clock-out pin
   input wire rtc_clk_in,
   output wire clock_out,
   // Static power controls, high means the circuit runs
   output wire regulator_enable,
   output wire reset_comparator_enable,
   output wire bandgap_enable,
   // Level interrupt
   output wire irq
);

   // Register state
   reg [`PM_WIDTH-1:0] power_mgmt_reg;
   reg [`PM_WIDTH-1:0] power_mgmt_next;
   reg [15:0] irq_mask_reg;
   reg [15:0] irq_mask_next;
   reg [15:0] wake_enable_reg;
   reg [15:0] wake_enable_next;
   reg [2:0] wake_cause_reg;
   reg [2:0] wake_cause_next;
   reg ready_reg;
   reg ready_next;
   reg [31:0] prdata_reg;
   reg slverr_reg;
   reg [15:0] read_word;
   reg read_hit;

   // Bus decode
   wire access;
   wire first_access;
   wire wr_done;
   wire rd_done;
   wire sel_flags;
   wire sel_pm;
   wire sel_irq_status;
   wire sel_irq_mask;
   wire sel_wake_en;
   wire sel_power_status;
   wire mapped;
   wire [15:0] byte_mask;
   wire [15:0] wr_bits;

   // Events and wake
   reg [15:0] event_bits;
   wire [15:0] flags;
   reg [15:0] flag_clear;
   wire [15:0] irq_status;
   reg [15:0] irq_status_clear;
   integer i;
   wire wake_direction;
   wire wake_data_out;
   wire wake_high;
   wire wake_rise;
   wire wake_by_pin;
   wire wake_by_alarm;
   wire wake_by_periodic;
   wire wake_request;
   wire power_down_any;
   wire [15:0] power_status;

   // ------------------------------------------------------------------
   // APB decode. One wait state so that read data can come from a flop.
   // ------------------------------------------------------------------
   assign access = psel & penable;
   assign first_access = access & ~ready_reg;
   assign wr_done = access & ready_reg & pwrite;
   assign rd_done = access & ready_reg & ~pwrite;

   assign sel_flags = (paddr == `EVENT_FLAGS_ADDR);
   assign sel_pm = (paddr == `POWER_MGMT_ADDR);
   assign sel_irq_status = (paddr == `IRQ_STATUS_ADDR);
   assign sel_irq_mask = (paddr == `IRQ_MASK_ADDR);
   assign sel_wake_en = (paddr == `WAKE_ENABLE_ADDR);
   assign sel_power_status = (paddr == `POWER_STATUS_ADDR);
   assign mapped = sel_flags | sel_pm | sel_irq_status | sel_irq_mask |
      sel_wake_en | sel_power_status;

   // Registers are 16 bits, so only the two low byte lanes matter
   assign byte_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wr_bits = pwdata[15:0] & byte_mask;

   // Phase of the access: load read data, then answer. The fixed wait
   // state keeps prdata off the address decode path.
   localparam APB_LOAD = 1'b0;
   localparam APB_ANSWER = 1'b1;

   always @* begin
      ready_next = APB_LOAD;
      case (ready_reg)
         APB_LOAD: begin
            if (access) begin
               ready_next = APB_ANSWER;
            end
         end
         APB_ANSWER: begin
            ready_next = APB_LOAD;
         end
         default: begin
            ready_next = APB_LOAD;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (srst) begin
         ready_reg <= APB_LOAD;
      end else begin
         ready_reg <= ready_next;
      end
   end

   assign pready = ready_reg;
   assign pslverr = slverr_reg & ready_reg;
   assign prdata = prdata_reg;

   // ------------------------------------------------------------------
   // Wake pin
   // ------------------------------------------------------------------
   assign wake_direction = power_mgmt_reg[`PM_WAKE_DIRECTION];
   assign wake_data_out = power_mgmt_reg[`PM_WAKE_DATA_OUT];

   wake_pin_io pin_io (
      .mclk(mclk),
      .srst(srst),
      .direction_out(wake_direction),
      .data_out(wake_data_out),
      .pin_in(wake_pin_in),
      .pin_out(wake_pin_out),
      .pin_oe(wake_pin_oe),
      .pin_high(wake_high),
      .pin_rise(wake_rise)
   );

   // ------------------------------------------------------------------
   // Event flags, write one to clear
   // ------------------------------------------------------------------
   // Fixed bit positions, so a build with fewer periodic sources keeps the map
   always @* begin
      event_bits = 16'h0000;
      for (i = 0; i < PERIODIC_EVENTS; i = i + 1) begin
         if (i <= `FL_DAY) begin
            event_bits[i] = periodic_event[i];
         end
      end
      event_bits[`FL_EXTERNAL] = wake_rise;
      event_bits[`FL_ALARM] = alarm_event;
   end

   always @* begin
      flag_clear = 16'h0000;
      if (wr_done & sel_flags) begin
         flag_clear = wr_bits;
      end
   end

   sticky_bits #(
      .WIDTH(16),
      .IMPL(`FL_IMPL_MASK)
   ) event_flags (
      .mclk(mclk),
      .srst(srst),
      .set_bits(event_bits),
      .clear_bits(flag_clear),
      .bits(flags)
   );

   // ------------------------------------------------------------------
   // Interrupt status, cleared by reading it
   // ------------------------------------------------------------------
   // Clear only what went out on the bus: an event that lands after the
   // read data was loaded stays pending for the next read
   always @* begin
      irq_status_clear = 16'h0000;
      if (rd_done & sel_irq_status) begin
         irq_status_clear = prdata_reg[15:0];
      end
   end

   sticky_bits #(
      .WIDTH(16),
      .IMPL(`FL_IMPL_MASK)
   ) irq_sticky (
      .mclk(mclk),
      .srst(srst),
      .set_bits(event_bits),
      .clear_bits(irq_status_clear),
      .bits(irq_status)
   );

   assign irq = |(irq_status & irq_mask_reg);

   // ------------------------------------------------------------------
   // Wake sources that end a static power-down
   // ------------------------------------------------------------------
   assign wake_by_pin = wake_high;
   assign wake_by_alarm = alarm_event & wake_enable_reg[`FL_ALARM];
   assign wake_by_periodic = |(periodic_event &
      wake_enable_reg[PERIODIC_EVENTS-1:0]);
   assign wake_request = wake_by_pin | wake_by_alarm | wake_by_periodic;
   assign power_down_any = power_mgmt_reg[`PM_BANDGAP_POWER_DOWN] |
      power_mgmt_reg[`PM_REGULATOR_POWER_DOWN];

   // ------------------------------------------------------------------
   // Power management register
   // ------------------------------------------------------------------
   always @* begin
      power_mgmt_next = power_mgmt_reg;
      if (wr_done & sel_pm & pstrb[0]) begin
         power_mgmt_next = pwdata[`PM_WIDTH-1:0];
      end
      // Wake leaves the power-down state even against a same-cycle write,
      // so a wake pin held high keeps the supplies up
      if (wake_request) begin
         power_mgmt_next[`PM_BANDGAP_POWER_DOWN] = 1'b0;
         power_mgmt_next[`PM_REGULATOR_POWER_DOWN] = 1'b0;
      end
   end

   always @* begin
      wake_cause_next = wake_cause_reg;
      if (wake_request & power_down_any) begin
         wake_cause_next = {wake_by_periodic, wake_by_alarm, wake_by_pin};
      end
   end

   always @* begin
      irq_mask_next = irq_mask_reg;
      wake_enable_next = wake_enable_reg;
      if (wr_done & sel_irq_mask) begin
         irq_mask_next = ((irq_mask_reg & ~byte_mask) | wr_bits) & `FL_IMPL_MASK;
      end
      if (wr_done & sel_wake_en) begin
         wake_enable_next = ((wake_enable_reg & ~byte_mask) | wr_bits) &
            `FL_IMPL_MASK;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         power_mgmt_reg <= `PM_RESET;
         irq_mask_reg <= `FL_RESET;
         wake_enable_reg <= `WAKE_EN_RESET;
         wake_cause_reg <= 3'h0;
      end else begin
         power_mgmt_reg <= power_mgmt_next;
         irq_mask_reg <= irq_mask_next;
         wake_enable_reg <= wake_enable_next;
         wake_cause_reg <= wake_cause_next;
      end
   end

   // ------------------------------------------------------------------
   // Static power outputs. The bandgap survives a regulator-only
   // power-down for a quicker restart, at the cost of its own current.
   // Bypassed regulators make these outputs meaningless; software must
   // then leave both bits clear.
   // ------------------------------------------------------------------
   assign regulator_enable = ~power_down_any;
   assign reset_comparator_enable = ~power_down_any;
   assign bandgap_enable = ~power_mgmt_reg[`PM_BANDGAP_POWER_DOWN];

   // Glitch-free only if the enable changes while the RTC clock is low;
   // the enable is a static setting so that trade is accepted
   assign clock_out = rtc_clk_in & power_mgmt_reg[`PM_CLOCK_OUT_ENABLE];

   // ------------------------------------------------------------------
   // Read data, captured in the first access cycle
   // ------------------------------------------------------------------
   assign power_status = {9'h000, wake_cause_reg, 1'b0, wake_high,
      bandgap_enable, regulator_enable};

   always @* begin
      read_word = 16'h0000;
      read_hit = 1'b1;
      if (sel_flags) begin
         read_word = flags;
      end else if (sel_pm) begin
         read_word = {11'h000, power_mgmt_reg};
      end else if (sel_irq_status) begin
         read_word = irq_status;
      end else if (sel_irq_mask) begin
         read_word = irq_mask_reg;
      end else if (sel_wake_en) begin
         read_word = wake_enable_reg;
      end else if (sel_power_status) begin
         read_word = power_status;
      end else begin
         read_hit = 1'b0;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         prdata_reg <= 32'h00000000;
         slverr_reg <= 1'b0;
      end else if (first_access) begin
         prdata_reg <= pwrite ? 32'h00000000 : {16'h0000, read_word};
         slverr_reg <= ~(read_hit & mapped);
      end
   end

endmodule

`default_nettype wire

// ### hw/rtc_pwr_regs.vh
// Register map, field positions and reset values of the RTC power and wake block
`ifndef RTC_PWR_REGS_VH
`define RTC_PWR_REGS_VH

// Byte addresses on the register bus
`define EVENT_FLAGS_ADDR 16'h1920
`define POWER_MGMT_ADDR 16'h1930
`define IRQ_STATUS_ADDR 16'h1940
`define IRQ_MASK_ADDR 16'h1944
`define WAKE_ENABLE_ADDR 16'h1948
`define POWER_STATUS_ADDR 16'h194c

// Power management fields
`define PM_CLOCK_OUT_ENABLE 0
`define PM_REGULATOR_POWER_DOWN 1
`define PM_BANDGAP_POWER_DOWN 2
`define PM_WAKE_DIRECTION 3
`define PM_WAKE_DATA_OUT 4
`define PM_RESET 5'h10
`define PM_WIDTH 5

// Event flag fields, shared by flags, irq status, irq mask and wake enable
`define FL_MILLISECOND 0
`define FL_SECOND 1
`define FL_MINUTE 2
`define FL_HOUR 3
`define FL_DAY 4
`define FL_EXTERNAL 5
`define FL_ALARM 15
`define FL_IMPL_MASK 16'h803f
`define FL_RESET 16'h0000
`define WAKE_EN_RESET 16'h0000

// Power status fields (read only)
`define PS_REGULATOR_ENABLE 0
`define PS_BANDGAP_ENABLE 1
`define PS_WAKE_PIN_LEVEL 2
`define PS_CAUSE_PIN 4
`define PS_CAUSE_ALARM 5
`define PS_CAUSE_PERIODIC 6

`endif

// ### hw/sticky_bits.v
// Sticky status bits: hardware sets, a clear strobe clears, set wins
`timescale 1ns/1ps
`default_nettype none

module sticky_bits #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] IMPL = {WIDTH{1'b1}}
) (
   input wire mclk,
   input wire srst,
   input wire [WIDTH-1:0] set_bits,
   input wire [WIDTH-1:0] clear_bits,
   output wire [WIDTH-1:0] bits
);

   reg [WIDTH-1:0] bits_reg;
   wire [WIDTH-1:0] bits_next;

   // A set arriving with its clear is kept; reserved bits never hold a one
   assign bits_next = ((bits_reg & ~clear_bits) | set_bits) & IMPL;

   always @(posedge mclk) begin
      if (srst) begin
         bits_reg <= {WIDTH{1'b0}};
      end else begin
         bits_reg <= bits_next;
      end
   end

   assign bits = bits_reg;

endmodule

`default_nettype wire

// ### hw/wake_pin_io.v
// Wake pin pad control: open-drain output and active-high input detection
`timescale 1ns/1ps
`default_nettype none

module wake_pin_io (
   input wire mclk,
   input wire srst,
   input wire direction_out,
   input wire data_out,
   input wire pin_in,
   output wire pin_out,
   output wire pin_oe,
   output wire pin_high,
   output wire pin_rise
);

   reg pin_last_reg;

   // Open drain: only ever pulls low, a one floats for the board pull-up
   assign pin_out = 1'b0;
   assign pin_oe = direction_out & ~data_out;

   // As an input the pin is active high; ignored while we own it
   assign pin_high = ~direction_out & pin_in;

   always @(posedge mclk) begin
      if (srst) begin
         pin_last_reg <= 1'b0;
      end else begin
         pin_last_reg <= pin_high;
      end
   end

   assign pin_rise = pin_high & ~pin_last_reg;

endmodule

`default_nettype wire

// ### verif/rtc_pwr_props.sv
// Port checks for the RTC power and wake block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pwr_regs.vh"
module rtc_pwr_props #(
   parameter ADDR_WIDTH = 16,
   parameter PERIODIC_EVENTS = 5
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic alarm_event,
   input wire logic [PERIODIC_EVENTS-1:0] periodic_event,
   input wire logic wake_pin_in,
   input wire logic wake_pin_out,
   input wire logic wake_pin_oe,
   input wire logic rtc_clk_in,
   input wire logic clock_out,
   input wire logic regulator_enable,
   input wire logic reset_comparator_enable,
   input wire logic bandgap_enable,
   input wire logic irq
);
   logic dir_q, dout_q, ck_q;
   wire pm_wr = psel && penable && pready && pwrite && pstrb[0] && paddr == `POWER_MGMT_ADDR;
   wire quiet = !alarm_event && periodic_event == 0 && !(wake_pin_in && !dir_q);
   // Wake clears only the power-down bits, so these shadows stay exact
   always @(posedge mclk) begin
      if (srst) begin
         dir_q <= 1'b0;
         dout_q <= 1'b1;
         ck_q <= 1'b0;
      end else if (pm_wr) begin
         dir_q <= pwdata[`PM_WAKE_DIRECTION];
         dout_q <= pwdata[`PM_WAKE_DATA_OUT];
         ck_q <= pwdata[`PM_CLOCK_OUT_ENABLE];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access with data");
   AST_RD_HIGH: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   AST_PIN_LOW: assert property (wake_pin_out == 1'b0)
      else $error("wake pin driven high");
   AST_OE: assert property (wake_pin_oe == (dir_q && !dout_q))
      else $error("wake pin enable wrong");
   AST_CLKOUT: assert property (clock_out == (ck_q && rtc_clk_in))
      else $error("clock out not gated");
   AST_BG_ALL: assert property (!bandgap_enable |-> !regulator_enable)
      else $error("regulator on without bandgap");
   AST_REG_CMP: assert property (regulator_enable == reset_comparator_enable)
      else $error("comparator differs from regulator");
   AST_REG_PD: assert property (pm_wr && quiet && pwdata[1] && !pwdata[2]
      |=> !regulator_enable && bandgap_enable)
      else $error("regulator power-down wrong");
   AST_BANDGAP_POWER_DOWN: assert property (pm_wr && quiet && pwdata[2] |=> !bandgap_enable)
      else $error("bandgap power-down ignored");
   AST_PIN_WAKE: assert property (!dir_q && wake_pin_in && !regulator_enable
      |-> ##[1:3] regulator_enable && bandgap_enable)
      else $error("pin did not wake");
endmodule
bind rtc_domain_power_wake_control rtc_pwr_props #(.ADDR_WIDTH(ADDR_WIDTH),
   .PERIODIC_EVENTS(PERIODIC_EVENTS)) rtc_pwr_props_inst (.mclk(mclk), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .alarm_event(alarm_event), .periodic_event(periodic_event), .wake_pin_in(wake_pin_in),
   .wake_pin_out(wake_pin_out), .wake_pin_oe(wake_pin_oe), .rtc_clk_in(rtc_clk_in),
   .clock_out(clock_out), .regulator_enable(regulator_enable),
   .reset_comparator_enable(reset_comparator_enable), .bandgap_enable(bandgap_enable),
   .irq(irq));
`default_nettype wire

// ### verif/wake_board.sv
// Board side of the wake pin: pull-up, external source and pin sink
`timescale 1ns/1ps
`default_nettype none
module wake_board (
   input wire logic oe,
   input wire logic drive_en,
   input wire logic drive_level,
   output logic pin
);
   // Device sink wins any fight; the pull-up holds an idle line high
   assign pin = oe ? 1'b0 : (drive_en ? drive_level : 1'b1);
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the RTC power and wake block
`timescale 1ns/1ps
`default_nettype none
`include "rtc_pwr_regs.vh"
module tb_top;
   logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, alarm_event = 0;
   logic rtc_clk_in = 0, ext_en = 1, ext_lvl = 0;
   logic [15:0] paddr = 0, acc = 0;
   logic [31:0] pwdata = 0, v, m;
   logic [3:0] pstrb = 4'h3;
   logic [4:0] periodic_event = 0;
   logic [32:0] exp_q[$];
   wire pready, pslverr, wake_pin_in, wake_pin_oe, clock_out, irq;
   wire regulator_enable, reset_comparator_enable, bandgap_enable;
   wire [31:0] prdata;
   int num_errors = 0, compares = 0, cycles = 0, seed = 32'hc98fb613;
   rtc_domain_power_wake_control #(.ADDR_WIDTH(16), .PERIODIC_EVENTS(5))
   rtc_domain_power_wake_control_inst (.mclk(mclk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .alarm_event(alarm_event),
      .periodic_event(periodic_event), .wake_pin_in(wake_pin_in), .wake_pin_out(),
      .wake_pin_oe(wake_pin_oe), .rtc_clk_in(rtc_clk_in), .clock_out(clock_out),
      .regulator_enable(regulator_enable), .reset_comparator_enable(reset_comparator_enable),
      .bandgap_enable(bandgap_enable), .irq(irq));
   wake_board wake_board_inst (.oe(wake_pin_oe), .drive_en(ext_en), .drive_level(ext_lvl),
      .pin(wake_pin_in));
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) rtc_clk_in <= ~rtc_clk_in;
   task test_done;
      $display("Counts: %0d compares, %0d errors", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [32:0] got, input logic [32:0] e);
      compares++;
      if (got !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
      if (!wr) exp_q.push_back(e);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk) penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   // Order: clock_out, irq, wake_pin_oe, regulator, comparator, bandgap
   task outs(input logic ck, input logic [4:0] e);
      @(negedge mclk);
      chk({clock_out, irq, wake_pin_oe, regulator_enable, reset_comparator_enable,
         bandgap_enable}, {ck & rtc_clk_in, e});
      @(posedge mclk);
   endtask
   task pulse(input logic a, input logic [4:0] p);
      alarm_event <= a;
      periodic_event <= p;
      @(posedge mclk);
      alarm_event <= 0;
      periodic_event <= 0;
      @(posedge mclk);
   endtask
   always @(posedge mclk) if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_q.pop_front());
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 5000) begin
         num_errors++;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 0;
      @(posedge mclk);
      apb(0, `POWER_MGMT_ADDR, 0, 33'h10);
      apb(0, `EVENT_FLAGS_ADDR, 0, 33'h0);
      apb(0, 16'h1924, 0, {1'b1, 32'h0});
      outs(0, 5'b00111);
      $display("Test reset done");
      apb(1, `IRQ_MASK_ADDR, 32'h1, 0);
      pulse(0, 5'h02);
      outs(0, 5'b00111);
      pulse(0, 5'h01);
      outs(0, 5'b10111);
      apb(0, `IRQ_STATUS_ADDR, 0, 33'h3);
      outs(0, 5'b00111);
      apb(1, `IRQ_MASK_ADDR, 32'h0, 0);
      apb(1, `EVENT_FLAGS_ADDR, 32'h3, 0);
      $display("Test interrupt done");
      apb(1, `POWER_MGMT_ADDR, 32'hffe1, 0);
      apb(0, `POWER_MGMT_ADDR, 0, 33'h01);
      outs(1, 5'b00111);
      outs(1, 5'b00111);
      apb(1, `POWER_MGMT_ADDR, 32'h08, 0);
      outs(0, 5'b01111);
      chk(wake_pin_in, 0);
      ext_en <= 0;
      apb(1, `POWER_MGMT_ADDR, 32'h18, 0);
      chk(wake_pin_in, 1);
      ext_en <= 1;
      apb(1, `POWER_MGMT_ADDR, 32'h10, 0);
      apb(0, `EVENT_FLAGS_ADDR, 0, 33'h0);
      $display("Test pin and clock done");
      repeat (4) begin
         v = $random(seed);
         m = $random(seed);
         pulse(v[5], v[4:0]);
         acc = acc | {v[5], 10'h0, v[4:0]};
         apb(0, `EVENT_FLAGS_ADDR, 0, {17'h0, acc});
         apb(1, `EVENT_FLAGS_ADDR, m, 0);
         acc = acc & ~m[15:0];
      end
      apb(0, `EVENT_FLAGS_ADDR, 0, {17'h0, acc});
      $display("Test flags done");
      // Regulators are never bypassed here, so power-down is legal
      apb(1, `WAKE_ENABLE_ADDR, 32'h8000, 0);
      apb(1, `POWER_MGMT_ADDR, 32'h12, 0);
      outs(0, 5'b00001);
      pulse(0, 5'h01);
      outs(0, 5'b00001);
      pulse(1, 5'h00);
      outs(0, 5'b00111);
      apb(1, `WAKE_ENABLE_ADDR, 32'h0002, 0);
      apb(1, `POWER_MGMT_ADDR, 32'h14, 0);
      outs(0, 5'b00000);
      pulse(1, 5'h00);
      outs(0, 5'b00000);
      pulse(0, 5'h02);
      outs(0, 5'b00111);
      apb(1, `POWER_MGMT_ADDR, 32'h14, 0);
      ext_lvl <= 1;
      repeat (3) @(posedge mclk);
      outs(0, 5'b00111);
      ext_lvl <= 0;
      apb(0, `POWER_STATUS_ADDR, 0, 33'h13);
      apb(0, `EVENT_FLAGS_ADDR, 0, {17'h0, acc | 16'h8023});
      $display("Test power done");
      test_done;
   end
endmodule
`default_nettype wire
